/* inc/bofd_consts.svh */
`ifndef BOFD_CONSTS_SVH
`define BOFD_CONSTS_SVH
// addressing byte fields
`define BOFD_MOD_NODISP 2'h0
`define BOFD_MOD_DISP8 2'h1
`define BOFD_MOD_DISP16 2'h2
`define BOFD_MOD_REG 2'h3
`define BOFD_RM_DIRECT 3'h6
// flag word bit positions
`define BOFD_FLAG_OF 11
`define BOFD_FLAG_DF 10
`define BOFD_FLAG_IF 9
`define BOFD_FLAG_TF 8
`define BOFD_FLAG_SF 7
`define BOFD_FLAG_ZERO 6
`define BOFD_FLAG_AF 4
`define BOFD_FLAG_PF 2
`define BOFD_FLAG_CF 0
// second byte of the ascii adjust pair, and the single shift count
`define BOFD_AAX_SECOND 8'h0A
`define BOFD_SHIFT_ONE 8'h01
// register map
`define BOFD_ADR_CTRL 8'h00
`define BOFD_ADR_STATUS 8'h04
`define BOFD_ADR_COUNT 8'h08
`define BOFD_CTRL_RST 1'h1
`define BOFD_CTRL_EN_BIT 0
`define BOFD_CTRL_CLR_BIT 1
`define BOFD_ST_LEN_LSB 0
`define BOFD_ST_OP_LSB 8
`define BOFD_ST_ILL_BIT 16
`define BOFD_ST_BUSY_BIT 17
`endif

/* inc/bofd_pkg.sv */
package bofd_pkg;
  typedef enum logic [4:0] {
    op_unknown, op_alu, op_alu_imm, op_incdec, op_adjust, op_jcc, op_test, op_not, op_neg,
    op_unsigned_multiply, op_signed_multiply, op_unsigned_divide, op_signed_divide, op_shift,
    op_byte_to_word_extend, op_word_to_dword_extend, op_ascii_mult_adjust, op_ascii_div_adjust,
    op_string, op_loop, op_loop_zero, op_loop_not_zero, op_jump_if_count_zero, op_call, op_jmp,
    op_return_near, op_return_far, op_interrupt, op_control, op_escape, op_prefix
  } bofd_op_t;

  typedef enum logic [2:0] {
    sh_rol, sh_ror, sh_rcl, sh_rcr, shift_left_op, sh_shr, sh_none, sh_sar
  } bofd_shift_t;

  typedef enum logic [3:0] {
    gpr_word_accumulator, gpr_count_register, gpr_dx, gpr_bx, gpr_stack_pointer, gpr_bp,
    gpr_si, gpr_di, gpr_byte_accumulator, gpr_count_low_byte, gpr_dl, gpr_bl, gpr_ah,
    gpr_ch, gpr_dh, gpr_bh
  } bofd_gpr_t;

  typedef struct packed {
    bofd_op_t op;
    logic modrm;
    logic [2:0] tail;
    logic sx;
  } bofd_opinfo_t;
endpackage : bofd_pkg

/* verilog/bofd_ea_calc.sv */
`timescale 1ns/100ps
`include "bofd_consts.svh"
module bofd_addr_calc (
  input logic [1:0] mod_i,
  input logic [2:0] rm_i,
  input logic [15:0] disp_raw_i,
  input logic [15:0] bx_i,
  input logic [15:0] bp_i,
  input logic [15:0] si_i,
  input logic [15:0] di_i,
  output logic [15:0] disp_o,
  output logic [15:0] effective_address_o
);
  logic direct;

  always_comb begin
    direct = (mod_i == `BOFD_MOD_NODISP) && (rm_i == `BOFD_RM_DIRECT);
    case (mod_i)
      `BOFD_MOD_DISP8: disp_o = {{8{disp_raw_i[7]}}, disp_raw_i[7:0]};
      `BOFD_MOD_DISP16: disp_o = disp_raw_i;
      `BOFD_MOD_NODISP: disp_o = direct ? disp_raw_i : 16'h0000;
      default: disp_o = 16'h0000;
    endcase
    case (rm_i)
      3'h0: effective_address_o = bx_i + si_i + disp_o;
      3'h1: effective_address_o = bx_i + di_i + disp_o;
      3'h2: effective_address_o = bp_i + si_i + disp_o;
      3'h3: effective_address_o = bp_i + di_i + disp_o;
      3'h4: effective_address_o = si_i + disp_o;
      3'h5: effective_address_o = di_i + disp_o;
      3'h6: effective_address_o = bp_i + disp_o;
      default: effective_address_o = bx_i + disp_o;
    endcase
    // direct address replaces the base register form
    if (direct) begin
      effective_address_o = disp_o;
    end
    if (mod_i == `BOFD_MOD_REG) begin
      effective_address_o = 16'h0000;
    end
  end
endmodule : bofd_addr_calc

/* verilog/bofd_cond_eval.sv */
`timescale 1ns/100ps
`include "bofd_consts.svh"
module bofd_cond_eval (
  input logic [3:0] cond_i,
  input logic [15:0] flags_i,
  output logic taken_o
);
  logic of, cf, zero_flag, sf, pf, t;

  always_comb begin
    of = flags_i[`BOFD_FLAG_OF];
    cf = flags_i[`BOFD_FLAG_CF];
    zero_flag = flags_i[`BOFD_FLAG_ZERO];
    sf = flags_i[`BOFD_FLAG_SF];
    pf = flags_i[`BOFD_FLAG_PF];
    case (cond_i[3:1])
      3'h0: t = of;
      3'h1: t = cf;
      3'h2: t = zero_flag;
      3'h3: t = cf | zero_flag;
      3'h4: t = sf;
      3'h5: t = pf;
      3'h6: t = sf ^ of;
      default: t = (sf ^ of) | zero_flag;
    endcase
    // odd codes are the negated condition
    taken_o = t ^ cond_i[0];
  end
endmodule : bofd_cond_eval

/* verilog/bofd_decoder.sv */
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/100ps
`include "bofd_consts.svh"
// Functional notes
// - direction bit set makes register field destination
// - width bit one means word, zero byte
// - mode 11 makes r/m a register number
// - mode 00 no displacement, except direct address
// - mode 01 one byte, sign-extended
// - mode 10 two bytes, low first
// - effective address from base/index per r/m
// - displacement bytes come before immediate bytes
// - immediate group s:w 01 takes two bytes
// - immediate group s:w 11 sign-extends one byte
// - shift count one, or count low byte
// - repeat prefix low bit selects zero flag
// - register field names word or byte registers
// - flag word bit positions fixed
// - upper nibble 0111 is conditional jump
// - above/below unsigned, greater/less signed
// - loop family opcodes with one displacement
// - group 1111011w reg 100-111 multiply/divide
// - shift group reg field selects shift kind
// - ascii adjusts are two bytes, second 0A
// - near return with 16-bit stack adjust
// - byte-to-word and word-to-dword extend opcodes
module bofd_decoder (
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input logic [7:0] byte_i,
  input logic byte_valid_i,
  output logic byte_ready_o,
  input logic [15:0] bx_i,
  input logic [15:0] bp_i,
  input logic [15:0] si_i,
  input logic [15:0] di_i,
  input logic [7:0] count_low_byte_i,
  input logic [15:0] flags_i,
  output logic insn_valid_o,
  output bofd_pkg::bofd_op_t op_o,
  output logic [7:0] opcode_o,
  output logic word_o,
  output logic rm_is_reg_o,
  output bofd_pkg::bofd_gpr_t dst_reg_o,
  output bofd_pkg::bofd_gpr_t src_reg_o,
  output logic [2:0] sub_op_o,
  output bofd_pkg::bofd_shift_t shift_kind_o,
  output logic [7:0] shift_count_o,
  output logic [15:0] disp_o,
  output logic [15:0] effective_address_o,
  output logic [15:0] imm_o,
  output logic [15:0] far_seg_o,
  output logic cond_taken_o,
  output logic repeat_prefix_o,
  output logic rpt_zero_flag_o,
  output logic illegal_o,
  output logic [3:0] length_o
);
  typedef enum logic [2:0] {st_op, st_modrm, st_disp, st_tail, st_emit} bofd_state_t;

  bofd_state_t st_q;
  bofd_pkg::bofd_op_t op_q;
  logic [7:0] opc_q, modrm_q;
  logic [1:0] disp_left_q, disp_idx_q;
  logic [2:0] tail_left_q, tail_idx_q;
  logic sx_q, rpt_q, rpt_zsel_q;
  logic [15:0] disp_raw_q;
  logic [31:0] imm_q;
  logic [3:0] len_q;
  logic en_q, ill_q, sticky_ill_q, ack_q;
  logic [15:0] count_q;
  logic take;
  bofd_pkg::bofd_opinfo_t info;
  logic [1:0] dcnt;
  logic [2:0] tcnt;
  logic tsx;
  bofd_pkg::bofd_op_t mop;
  logic [15:0] addr_disp, addr_val;
  logic taken;
  logic [1:0] sw;
  logic wb_hit, wb_wr;

  // sizing of the first byte; groups are refined at the addressing byte
  function automatic bofd_pkg::bofd_opinfo_t opinfo(input logic [7:0] b);
    bofd_pkg::bofd_opinfo_t r;
    r = '{op: bofd_pkg::op_unknown, modrm: 1'b0, tail: 3'h0, sx: 1'b0};
    casez (b)
      8'b001??110, 8'hF2, 8'hF3: r.op = bofd_pkg::op_prefix;
      8'b00???0??: begin
        r.op = bofd_pkg::op_alu;
        r.modrm = 1'b1;
      end
      8'b00???10?: begin
        r.op = bofd_pkg::op_alu;
        r.tail = b[0] ? 3'h2 : 3'h1;
      end
      8'b00???11?: r.op = bofd_pkg::op_adjust;
      8'h4?: r.op = bofd_pkg::op_incdec;
      8'h7?: begin
        r.op = bofd_pkg::op_jcc;
        r.tail = 3'h1;
        r.sx = 1'b1;
      end
      8'b100000??: begin
        r.op = bofd_pkg::op_alu_imm;
        r.modrm = 1'b1;
      end
      8'b1000010?: begin
        r.op = bofd_pkg::op_test;
        r.modrm = 1'b1;
      end
      8'h98: r.op = bofd_pkg::op_byte_to_word_extend;
      8'h99: r.op = bofd_pkg::op_word_to_dword_extend;
      8'h9A: begin
        r.op = bofd_pkg::op_call;
        r.tail = 3'h4;
      end
      8'h9B, 8'hF4, 8'hF5, 8'b111110??, 8'b1111110?: r.op = bofd_pkg::op_control;
      8'b1010100?: begin
        r.op = bofd_pkg::op_test;
        r.tail = b[0] ? 3'h2 : 3'h1;
      end
      8'b101001??, 8'b1010101?, 8'b101011??: r.op = bofd_pkg::op_string;
      8'hC2, 8'hC3: begin
        r.op = bofd_pkg::op_return_near;
        r.tail = b[0] ? 3'h0 : 3'h2;
      end
      8'hCA, 8'hCB: begin
        r.op = bofd_pkg::op_return_far;
        r.tail = b[0] ? 3'h0 : 3'h2;
      end
      8'hCD: begin
        r.op = bofd_pkg::op_interrupt;
        r.tail = 3'h1;
      end
      8'hCC, 8'hCE, 8'hCF: r.op = bofd_pkg::op_interrupt;
      8'b110100??: begin
        r.op = bofd_pkg::op_shift;
        r.modrm = 1'b1;
      end
      8'hD4, 8'hD5: begin
        r.op = b[0] ? bofd_pkg::op_ascii_div_adjust : bofd_pkg::op_ascii_mult_adjust;
        r.tail = 3'h1;
      end
      8'b11011???: begin
        r.op = bofd_pkg::op_escape;
        r.modrm = 1'b1;
      end
      8'b111000??: begin
        case (b[1:0])
          2'h0: r.op = bofd_pkg::op_loop_not_zero;
          2'h1: r.op = bofd_pkg::op_loop_zero;
          2'h2: r.op = bofd_pkg::op_loop;
          default: r.op = bofd_pkg::op_jump_if_count_zero;
        endcase
        r.tail = 3'h1;
        r.sx = 1'b1;
      end
      8'hE8, 8'hE9, 8'hEA, 8'hEB: begin
        r.op = (b == 8'hE8) ? bofd_pkg::op_call : bofd_pkg::op_jmp;
        r.tail = (b == 8'hEA) ? 3'h4 : ((b == 8'hEB) ? 3'h1 : 3'h2);
        r.sx = (b == 8'hEB);
      end
      8'b1111011?, 8'b1111111?: begin
        r.op = bofd_pkg::op_unknown;
        r.modrm = 1'b1;
      end
      default: r.op = bofd_pkg::op_unknown;
    endcase
    return r;
  endfunction : opinfo

  function automatic bofd_pkg::bofd_gpr_t gpr(input logic w, input logic [2:0] code);
    return bofd_pkg::bofd_gpr_t'({~w, code});
  endfunction : gpr

  assign byte_ready_o = en_q && (st_q != st_emit);
  assign take = byte_valid_i && byte_ready_o;

  always_comb begin
    info = opinfo(byte_i);
  end

  // addressing byte: displacement count and group refinement
  always_comb begin
    mop = op_q;
    tcnt = tail_left_q;
    tsx = sx_q;
    sw = opc_q[1:0];
    case (byte_i[7:6])
      `BOFD_MOD_NODISP: dcnt = (byte_i[2:0] == `BOFD_RM_DIRECT) ? 2'h2 : 2'h0;
      `BOFD_MOD_DISP8: dcnt = 2'h1;
      `BOFD_MOD_DISP16: dcnt = 2'h2;
      default: dcnt = 2'h0;
    endcase
    if (op_q == bofd_pkg::op_alu_imm) begin
      tcnt = (sw == 2'h1) ? 3'h2 : 3'h1;
      tsx = (sw == 2'h3);
    end else if (opc_q[7:1] == 7'h7B) begin
      case (byte_i[5:3])
        3'h0, 3'h1: begin
          mop = bofd_pkg::op_test;
          tcnt = opc_q[0] ? 3'h2 : 3'h1;
        end
        3'h2: mop = bofd_pkg::op_not;
        3'h3: mop = bofd_pkg::op_neg;
        3'h4: mop = bofd_pkg::op_unsigned_multiply;
        3'h5: mop = bofd_pkg::op_signed_multiply;
        3'h6: mop = bofd_pkg::op_unsigned_divide;
        default: mop = bofd_pkg::op_signed_divide;
      endcase
    end else if (opc_q[7:1] == 7'h7F) begin
      case (byte_i[5:3])
        3'h0, 3'h1: mop = bofd_pkg::op_incdec;
        3'h2, 3'h3: mop = bofd_pkg::op_call;
        3'h4, 3'h5: mop = bofd_pkg::op_jmp;
        default: mop = bofd_pkg::op_unknown;
      endcase
    end
  end

  // sequencing over the byte stream
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= st_op;
      op_q <= bofd_pkg::op_unknown;
      opc_q <= 8'h00;
      modrm_q <= 8'h00;
      disp_left_q <= 2'h0;
      disp_idx_q <= 2'h0;
      tail_left_q <= 3'h0;
      tail_idx_q <= 3'h0;
      sx_q <= 1'b0;
      disp_raw_q <= 16'h0000;
      imm_q <= 32'h0000_0000;
      len_q <= 4'h0;
      rpt_q <= 1'b0;
      rpt_zsel_q <= 1'b0;
      ill_q <= 1'b0;
    end else begin
      case (st_q)
        st_op: if (take) begin
          len_q <= len_q + 4'h1;
          opc_q <= byte_i;
          op_q <= info.op;
          tail_left_q <= info.tail;
          tail_idx_q <= 3'h0;
          sx_q <= info.sx;
          modrm_q <= 8'h00;
          disp_raw_q <= 16'h0000;
          imm_q <= 32'h0000_0000;
          ill_q <= (info.op == bofd_pkg::op_unknown) && !info.modrm;
          if (byte_i[7:1] == 7'h79) begin
            rpt_q <= 1'b1;
            rpt_zsel_q <= byte_i[0];
          end
          // prefixes stay here and count toward the next instruction
          if (info.op == bofd_pkg::op_prefix) begin
            st_q <= st_op;
          end else if (info.modrm) begin
            st_q <= st_modrm;
          end else if (info.tail != 3'h0) begin
            st_q <= st_tail;
          end else begin
            st_q <= st_emit;
          end
        end
        st_modrm: if (take) begin
          len_q <= len_q + 4'h1;
          modrm_q <= byte_i;
          op_q <= mop;
          tail_left_q <= tcnt;
          sx_q <= tsx;
          ill_q <= (mop == bofd_pkg::op_unknown);
          disp_left_q <= dcnt;
          disp_idx_q <= 2'h0;
          if (dcnt != 2'h0) begin
            st_q <= st_disp;
          end else if (tcnt != 3'h0) begin
            st_q <= st_tail;
          end else begin
            st_q <= st_emit;
          end
        end
        st_disp: if (take) begin
          len_q <= len_q + 4'h1;
          disp_raw_q[{disp_idx_q[0], 3'h0} +: 8] <= byte_i;
          disp_idx_q <= disp_idx_q + 2'h1;
          disp_left_q <= disp_left_q - 2'h1;
          if (disp_left_q == 2'h1) begin
            st_q <= (tail_left_q != 3'h0) ? st_tail : st_emit;
          end
        end
        st_tail: if (take) begin
          len_q <= len_q + 4'h1;
          imm_q[{tail_idx_q[1:0], 3'h0} +: 8] <= byte_i;
          tail_idx_q <= tail_idx_q + 3'h1;
          tail_left_q <= tail_left_q - 3'h1;
          if ((op_q == bofd_pkg::op_ascii_mult_adjust || op_q == bofd_pkg::op_ascii_div_adjust)
              && byte_i != `BOFD_AAX_SECOND) begin
            ill_q <= 1'b1;
          end
          if (tail_left_q == 3'h1) begin
            st_q <= st_emit;
          end
        end
        st_emit: begin
          st_q <= st_op;
          len_q <= 4'h0;
          rpt_q <= 1'b0;
          rpt_zsel_q <= 1'b0;
        end
        default: st_q <= st_op;
      endcase
    end
  end

  bofd_addr_calc u_addr (
    .mod_i(modrm_q[7:6]),
    .rm_i(modrm_q[2:0]),
    .disp_raw_i(disp_raw_q),
    .bx_i(bx_i),
    .bp_i(bp_i),
    .si_i(si_i),
    .di_i(di_i),
    .disp_o(addr_disp),
    .effective_address_o(addr_val)
  );

  bofd_cond_eval u_cond (
    .cond_i(opc_q[3:0]),
    .flags_i(flags_i),
    .taken_o(taken)
  );

  // decoded result, held until the next instruction is emitted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      insn_valid_o <= 1'b0;
      op_o <= bofd_pkg::op_unknown;
      opcode_o <= 8'h00;
      word_o <= 1'b0;
      rm_is_reg_o <= 1'b0;
      dst_reg_o <= bofd_pkg::gpr_word_accumulator;
      src_reg_o <= bofd_pkg::gpr_word_accumulator;
      sub_op_o <= 3'h0;
      shift_kind_o <= bofd_pkg::sh_none;
      shift_count_o <= 8'h00;
      disp_o <= 16'h0000;
      effective_address_o <= 16'h0000;
      imm_o <= 16'h0000;
      far_seg_o <= 16'h0000;
      cond_taken_o <= 1'b0;
      repeat_prefix_o <= 1'b0;
      rpt_zero_flag_o <= 1'b0;
      illegal_o <= 1'b0;
      length_o <= 4'h0;
    end else begin
      insn_valid_o <= (st_q == st_emit);
      if (st_q == st_emit) begin
        op_o <= op_q;
        opcode_o <= opc_q;
        length_o <= len_q;
        word_o <= (op_q == bofd_pkg::op_incdec && !opc_q[7]) || opc_q[0];
        rm_is_reg_o <= (modrm_q[7:6] == `BOFD_MOD_REG);
        sub_op_o <= (op_q == bofd_pkg::op_alu) ? opc_q[5:3] : modrm_q[5:3];
        if (op_q == bofd_pkg::op_alu && opc_q[1]) begin
          dst_reg_o <= gpr(opc_q[0], modrm_q[5:3]);
          src_reg_o <= gpr(opc_q[0], modrm_q[2:0]);
        end else begin
          dst_reg_o <= gpr(opc_q[0], modrm_q[2:0]);
          src_reg_o <= gpr(opc_q[0], modrm_q[5:3]);
        end
        if (op_q == bofd_pkg::op_incdec && !opc_q[7]) begin
          dst_reg_o <= gpr(1'b1, opc_q[2:0]);
        end
        shift_kind_o <= (op_q == bofd_pkg::op_shift) ?
                        bofd_pkg::bofd_shift_t'(modrm_q[5:3]) : bofd_pkg::sh_none;
        shift_count_o <= opc_q[1] ? count_low_byte_i : `BOFD_SHIFT_ONE;
        disp_o <= addr_disp;
        effective_address_o <= addr_val;
        // byte immediates and short displacements widen here
        if (tail_idx_q == 3'h1) begin
          imm_o <= sx_q ? {{8{imm_q[7]}}, imm_q[7:0]} : {8'h00, imm_q[7:0]};
        end else begin
          imm_o <= imm_q[15:0];
        end
        far_seg_o <= imm_q[31:16];
        cond_taken_o <= (op_q == bofd_pkg::op_jcc) && taken;
        repeat_prefix_o <= rpt_q;
        rpt_zero_flag_o <= rpt_zsel_q;
        illegal_o <= ill_q;
      end
    end
  end

  // wishbone slave: ack one cycle after the strobe, writes land on the ack edge
  assign wb_hit = wb_cyc_i && wb_stb_i;
  assign wb_wr = wb_hit && wb_we_i && ack_q && wb_sel_i[0];
  assign wb_ack_o = ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_q <= wb_hit && !ack_q;
      wb_dat_o <= 32'h0000_0000;
      if (wb_hit && !ack_q) begin
        case (wb_adr_i)
          `BOFD_ADR_CTRL: wb_dat_o[`BOFD_CTRL_EN_BIT] <= en_q;
          `BOFD_ADR_STATUS: begin
            wb_dat_o[`BOFD_ST_LEN_LSB +: 4] <= length_o;
            wb_dat_o[`BOFD_ST_OP_LSB +: 5] <= op_o;
            wb_dat_o[`BOFD_ST_ILL_BIT] <= sticky_ill_q;
            wb_dat_o[`BOFD_ST_BUSY_BIT] <= (st_q != st_op);
          end
          `BOFD_ADR_COUNT: wb_dat_o[15:0] <= count_q;
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= `BOFD_CTRL_RST;
    end else if (wb_wr && wb_adr_i == `BOFD_ADR_CTRL) begin
      en_q <= wb_dat_i[`BOFD_CTRL_EN_BIT];
    end
  end

  // set beats clear so an illegal decode in the clearing cycle is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sticky_ill_q <= 1'b0;
      count_q <= 16'h0000;
    end else begin
      if (st_q == st_emit && ill_q) begin
        sticky_ill_q <= 1'b1;
      end else if (wb_wr && wb_adr_i == `BOFD_ADR_CTRL && wb_dat_i[`BOFD_CTRL_CLR_BIT]) begin
        sticky_ill_q <= 1'b0;
      end
      if (st_q == st_emit) begin
        count_q <= count_q + 16'h0001;
      end
    end
  end
endmodule : bofd_decoder

/* sim/bofd_decoder_chk.sv */
`timescale 1ns/100ps
module bofd_decoder_chk (
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_ack_o,
  input logic [31:0] wb_dat_o,
  input logic byte_ready_o,
  input logic insn_valid_o,
  input bofd_pkg::bofd_op_t op_o,
  input logic [7:0] opcode_o,
  input logic rm_is_reg_o,
  input logic [15:0] effective_address_o,
  input logic [7:0] shift_count_o,
  input logic cond_taken_o,
  input logic repeat_prefix_o,
  input logic rpt_zero_flag_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("no ack one cycle after request");
  property p_ack_gap;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_gap: assert property (p_ack_gap) else $error("ack longer than one cycle");
  property p_rdat_zero;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_rdat_zero: assert property (p_rdat_zero) else $error("read data outside ack");
  // emit cycle refuses the next byte, so length is final before new bytes land
  property p_emit_gap;
    insn_valid_o |-> $past(byte_ready_o) == 1'b0;
  endproperty
  a_emit_gap: assert property (p_emit_gap) else $error("ready high in emit cycle");
  property p_iv_pulse;
    insn_valid_o |=> !insn_valid_o;
  endproperty
  a_iv_pulse: assert property (p_iv_pulse) else $error("insn valid not a pulse");
  property p_mode_reg;
    insn_valid_o && rm_is_reg_o |-> effective_address_o == 16'h0;
  endproperty
  a_mode_reg: assert property (p_mode_reg) else $error("address formed for register operand");
  property p_jcc;
    insn_valid_o && op_o == bofd_pkg::op_jcc |-> opcode_o[7:4] == 4'h7;
  endproperty
  a_jcc: assert property (p_jcc) else $error("branch class on wrong opcode");
  property p_cond;
    cond_taken_o |-> op_o == bofd_pkg::op_jcc;
  endproperty
  a_cond: assert property (p_cond) else $error("taken outside conditional jump");
  property p_rpt;
    insn_valid_o && rpt_zero_flag_o |-> repeat_prefix_o;
  endproperty
  a_rpt: assert property (p_rpt) else $error("zero select without repeat");
  property p_count1;
    insn_valid_o && op_o == bofd_pkg::op_shift && !opcode_o[1] |-> shift_count_o == 8'h01;
  endproperty
  a_count1: assert property (p_count1) else $error("single shift count wrong");
  c_taken: cover property (insn_valid_o && cond_taken_o);
  c_rpt: cover property (insn_valid_o && repeat_prefix_o);
  c_ack: cover property (wb_ack_o);
endmodule : bofd_decoder_chk

/* sim/bofd_fetch_model.sv */
`timescale 1ns/100ps
module bofd_fetch_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic byte_ready_i,
  output logic [7:0] byte_o,
  output logic byte_valid_o
);
  logic [7:0] q[$];
  logic [7:0] last_q;
  logic nxt;
  initial begin
    byte_o = 8'h00;
    byte_valid_o = 1'b0;
    last_q = 8'h00;
  end
  task push(input logic [7:0] b);
    q.push_back(b);
  endtask : push
  // stream order kept, so displacement bytes precede immediate bytes
  always @(posedge clk_i) begin
    if (byte_valid_o && byte_ready_i && !rst_i) begin
      last_q = q.pop_front();
    end
    // slow mode idles a cycle after each byte; an idle bus shows junk, not the old byte
    nxt = !rst_i && q.size() > 0 && !(slow_i && byte_valid_o && byte_ready_i);
    byte_valid_o <= nxt;
    byte_o <= nxt ? q[0] : ~last_q;
  end
endmodule : bofd_fetch_model

/* sim/bofd_decoder_test.sv */
`timescale 1ns/100ps
module bofd_decoder_test;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, byte_valid_i, byte_ready_o, insn_valid_o;
  logic word_o, rm_is_reg_o, cond_taken_o, repeat_prefix_o, rpt_zero_flag_o, illegal_o, slow;
  logic [7:0] wb_adr_i, byte_i, count_low_byte_i, opcode_o, shift_count_o;
  logic [3:0] wb_sel_i, length_o;
  logic [2:0] sub_op_o;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] bx_i, bp_i, si_i, di_i, flags_i, disp_o, effective_address_o, imm_o, far_seg_o;
  bofd_pkg::bofd_op_t op_o;
  bofd_pkg::bofd_gpr_t dst_reg_o, src_reg_o;
  bofd_pkg::bofd_shift_t shift_kind_o;
  int num_errors, cmp_count, n_insn;
  bofd_decoder i_dut (.*);
  bofd_fetch_model i_fetch (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .byte_ready_i(byte_ready_o),
    .byte_o(byte_i), .byte_valid_o(byte_valid_i));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task close_out;
    $display("errors %0d checks %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb
  task await(input int n);
    do @(posedge clk_i); while (insn_valid_o !== 1'b1);
    n_insn++;
    check(length_o, n);
  endtask : await
  task run(input logic [47:0] b, input int n);
    for (int k = 0; k < n; k++) i_fetch.push(b[8*k +: 8]);
    await(n);
  endtask : run
  task t_regs;
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h1);
    wb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h0);
  endtask : t_regs
  task t_alu;
    run(48'h1204, 2);
    check(op_o, bofd_pkg::op_alu);
    check({word_o, imm_o}, 17'h00012);
    run(48'h123405, 3);
    check({word_o, imm_o}, 17'h11234);
    run(48'hD801, 2);
    check({dst_reg_o, src_reg_o, rm_is_reg_o}, {bofd_pkg::gpr_word_accumulator, bofd_pkg::gpr_bx, 1'b1});
    run(48'hD803, 2);
    check({dst_reg_o, src_reg_o}, {bofd_pkg::gpr_bx, bofd_pkg::gpr_word_accumulator});
    run(48'hD802, 2);
    check({dst_reg_o, src_reg_o}, {bofd_pkg::gpr_bl, bofd_pkg::gpr_byte_accumulator});
  endtask : t_alu
  task t_am;
    static logic [15:0] base [8] = '{16'h1030, 16'h1004, 16'h2030, 16'h2004, 16'h0030, 16'h0004, 16'h2000, 16'h1000};
    for (int r = 0; r < 8; r++) begin
      run({24'h000100, 2'b10, 3'b000, r[2:0], 8'h03}, 4);
      check({disp_o, effective_address_o}, {16'h0100, base[r] + 16'h0100});
    end
    run(48'h804603, 3);
    check({disp_o, effective_address_o}, 32'hFF801F80);
    run(48'h0403, 2);
    check({disp_o, effective_address_o}, 32'h00000030);
    run(48'h56780603, 4);
    check(effective_address_o, 16'h5678);
    run(48'h12345678EA, 5);
    check({imm_o, far_seg_o}, 32'h56781234);
  endtask : t_am
  task t_imm;
    slow <= 1'b1;
    run(48'hABCD12340681, 6);
    check({effective_address_o, imm_o}, 32'h1234ABCD);
    run(48'hFEC083, 3);
    check({op_o, imm_o}, {bofd_pkg::op_alu_imm, 16'hFFFE});
    run(48'h7FC083, 3);
    check(imm_o, 16'h007F);
    slow <= 1'b0;
  endtask : t_imm
  task t_shift;
    count_low_byte_i <= 8'h05;
    run(48'hE0D3, 2);
    check({shift_kind_o, shift_count_o}, {bofd_pkg::shift_left_op, 8'h05});
    for (int r = 0; r < 8; r++) begin
      if (r != 6) begin
        run({2'b11, r[2:0], 3'b000, 8'hD0}, 2);
        check({shift_kind_o, shift_count_o, word_o}, {r[2:0], 8'h01, 1'b0});
      end
    end
    for (int r = 4; r < 8; r++) begin
      run({2'b11, r[2:0], 3'b001, 8'hF7}, 2);
      check(op_o, 32'(bofd_pkg::op_unsigned_multiply) + r - 4);
    end
  endtask : t_shift
  task jc(input logic [7:0] op, input logic [15:0] fl, input logic tk);
    flags_i <= fl;
    run({8'hFE, op}, 2);
    check({op_o, cond_taken_o, imm_o}, {bofd_pkg::op_jcc, tk, 16'hFFFE});
  endtask : jc
  task t_jcc;
    jc(8'h74, 16'h0040, 1'b1);
    jc(8'h75, 16'h0040, 1'b0);
    jc(8'h72, 16'h0000, 1'b0);
    jc(8'h77, 16'h0000, 1'b1);
    jc(8'h76, 16'h0001, 1'b1);
    jc(8'h7C, 16'h0080, 1'b1);
    jc(8'h7F, 16'h0880, 1'b1);
    jc(8'h7F, 16'h0800, 1'b0);
    jc(8'h7A, 16'h0004, 1'b1);
    jc(8'h70, 16'h0800, 1'b1);
  endtask : t_jcc
  task t_misc;
    run(48'h80E2, 2);
    check({op_o, imm_o}, {bofd_pkg::op_loop, 16'hFF80});
    run(48'h80E1, 2);
    check(op_o, bofd_pkg::op_loop_zero);
    run(48'h80E0, 2);
    check(op_o, bofd_pkg::op_loop_not_zero);
    run(48'h80E3, 2);
    check(op_o, bofd_pkg::op_jump_if_count_zero);
    run(48'h0AD4, 2);
    check({op_o, illegal_o}, {bofd_pkg::op_ascii_mult_adjust, 1'b0});
    run(48'h0AD5, 2);
    check({op_o, illegal_o}, {bofd_pkg::op_ascii_div_adjust, 1'b0});
    run(48'h0BD4, 2);
    check(illegal_o, 1'b1);
    wb(1'b0, 8'h04, 32'h0);
    check(rd[16], 1'b1);
    wb(1'b1, 8'h00, 32'h3);
    wb(1'b0, 8'h04, 32'h0);
    check(rd[16], 1'b0);
    run(48'h1234C2, 3);
    check({op_o, imm_o}, {bofd_pkg::op_return_near, 16'h1234});
    run(48'h98, 1);
    check(op_o, bofd_pkg::op_byte_to_word_extend);
    run(48'h99, 1);
    check(op_o, bofd_pkg::op_word_to_dword_extend);
    run(48'hA6F3, 2);
    check({repeat_prefix_o, rpt_zero_flag_o}, 2'b11);
    run(48'hAEF2, 2);
    check({repeat_prefix_o, rpt_zero_flag_o}, 2'b10);
  endtask : t_misc
  task t_enable;
    wb(1'b1, 8'h00, 32'h0);
    i_fetch.push(8'h98);
    repeat (5) @(posedge clk_i);
    check({byte_ready_o, insn_valid_o}, 2'b00);
    wb(1'b1, 8'h00, 32'h1);
    await(1);
    wb(1'b0, 8'h08, 32'h0);
    check(rd[15:0], n_insn[15:0]);
  endtask : t_enable
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    slow = 1'b0;
    bx_i = 16'h1000;
    bp_i = 16'h2000;
    si_i = 16'h0030;
    di_i = 16'h0004;
    count_low_byte_i = 8'h00;
    flags_i = 16'h0000;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_alu();
    t_am();
    t_imm();
    t_shift();
    t_jcc();
    t_misc();
    t_enable();
    close_out();
  end
  // run takes a few hundred cycles
  initial begin
    #200000;
    num_errors++;
    close_out();
  end
endmodule : bofd_decoder_test
bind bofd_decoder bofd_decoder_chk i_chk (.*);
